// >>> logic/cmc_cfg.svh
// Offsets, field positions, reset values and timing counts of the mode block.
`ifndef CMC_CFG_SVH
`define CMC_CFG_SVH
`define CMC_OFS_CTRL1   4'h0
`define CMC_OFS_CFG2    4'h4
`define CMC_OFS_BITDIV  4'h8
`define CMC_OFS_STATUS  4'hC
`define CMC_B_SIDL      13
`define CMC_B_ABORT     12
`define CMC_F_REQ_HI    10
`define CMC_F_REQ_LO    8
`define CMC_F_STA_HI    7
`define CMC_F_STA_LO    5
`define CMC_B_CAP       3
`define CMC_B_WIN       0
`define CMC_B_WAKFLT    14
`define CMC_CTRL1_RST   16'h0480
`define CMC_BITDIV_RST  16'h007D
`define CMC_IDLE_BITS   11
`define CMC_OVL_MAX     2
`define CMC_FILT_TAPS   4
`endif

// >>> logic/cmc_idle_det.sv
// Bus idle detector: counts consecutive recessive bits.
`timescale 1ns/100ps
`include "cmc_cfg.svh"
module cmc_idle_det #(
   parameter int IDLE_BITS = `CMC_IDLE_BITS
) (
   input  wire logic clock_in,    // module clock
   input  wire logic rst_n_in,    // async reset, active low
   input  wire logic bit_tick_in, // one pulse per bit time
   input  wire logic rx_in,       // synchronised bus level
   input  wire logic restart_in,  // forget idle history
   output logic      idle_out     // idle seen
);
   import cmc_pkg::*;
   localparam logic [4:0] LIMIT = 5'(IDLE_BITS);
   logic [4:0] cnt_r, cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (restart_in)
         cnt_nxt = 5'h00;
      else if (bit_tick_in && !rx_in)
         cnt_nxt = 5'h00;
      else if (bit_tick_in && cnt_r != LIMIT)
         cnt_nxt = cnt_r + 5'h01;
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in)
         cnt_r <= 5'h00;
      else
         cnt_r <= cnt_nxt;
   end

   assign idle_out = (cnt_r == LIMIT);
endmodule

// >>> logic/cmc_mode_ctrl.sv
// CAN operating-mode controller with Avalon-MM register slave.
//
// Overview of operation
// - Request at 10:8, entered mode at 7:5.
// - Leave normal, loopback or listen modes only after 11 recessive bits; config and disable need no idle bus.
// - Request codes: normal..config, listen-all; 101/110 reserved.
// - Config mode: no traffic, clear error counters.
// - cfg2, bit divider and SIDL writable only in config.
// - Config entry waits for running transmission.
// - Disable: no traffic, wake flag, counters held.
// - Disable waits idle bus unless entered from config; pins released.
// - Wake low-pass filter while sleeping, cfg2 bit 14.
// - Early disable aborts pending transmission.
// - Normal mode: engine on, pins are CAN.
// - Listen-only: passive, no transmit pin, counters off.
// - Listen-all: ignore errors, keep partial messages.
// - Loopback: internal tx to rx, pins released.
// - At most 2 consecutive overload frames.
// - Matching remote frame answered automatically.
`timescale 1ns/100ps
`include "cmc_cfg.svh"
module cmc_mode_ctrl #(
   parameter int IDLE_BITS = `CMC_IDLE_BITS,
   parameter int FILT_TAPS = `CMC_FILT_TAPS
) (
   input  wire logic        clock_in,          // 125 MHz module clock
   input  wire logic        rst_n_in,          // async reset, active low
   input  wire logic [3:0]  avs_address_in,    // byte address
   input  wire logic        avs_read_in,       // read request
   input  wire logic        avs_write_in,      // write request
   input  wire logic [31:0] avs_writedata_in,  // write data
   input  wire logic [3:0]  avs_byteenable_in, // byte lanes
   output logic [31:0]      avs_readdata_out,  // read data
   output logic             avs_waitrequest_out, // stall
   input  wire logic        can_rx_line_in,    // receive pin
   output logic             can_tx_line_out,   // transmit pin level
   output logic             can_tx_oe_out,     // transmit pin driven
   output logic             can_rx_own_out,    // rx pin owned by CAN
   input  wire logic        eng_tx_in,         // engine transmit bit
   output logic             eng_rx_out,        // engine receive bit
   output logic             bit_tick_out,      // bit-rate enable
   input  wire logic        tx_busy_in,        // frame being sent
   input  wire logic        tx_pending_in,     // a buffer requests tx
   input  wire logic        abort_done_in,     // all aborted
   input  wire logic        rx_done_in,        // message received
   input  wire logic        rtr_match_in,      // matching remote frame
   input  wire logic        ovl_req_in,        // engine wants overload
   input  wire logic        frame_start_in,    // start of frame seen
   input  wire logic        sleep_in,          // sleep state
   input  wire logic        cpu_idle_in,       // processor idle state
   output cmc_pkg::cmc_mode_e mode_status_out, // entered mode
   output logic             engine_en_out,     // protocol engine on
   output logic             tx_en_out,         // may start frames
   output logic             rx_en_out,         // may receive
   output logic             ack_err_en_out,    // may drive ack/errors
   output logic             err_clear_out,     // clear error counters
   output logic             err_hold_out,      // freeze error counters
   output logic             keep_partial_out,  // listen-all capture
   output logic             abort_all_out,     // abort every buffer
   output logic             tx_cancel_out,     // set aborted, drop req
   output logic             capture_out,       // timestamp pulse
   output logic             window_sel_out,    // 1 filters, 0 buffers
   output logic             halt_out,          // module halted
   output logic             ovl_grant_out,     // overload allowed
   output logic             auto_reply_out     // send data reply
);
   import cmc_pkg::*;

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic        sidl_r, sidl_nxt, abort_r, abort_nxt;
   logic [2:0]  req_r, req_nxt;
   cmc_mode_e   sta_r, sta_nxt;
   logic        cap_en_r, cap_en_nxt, win_r, win_nxt;
   logic        wakflt_r, wakflt_nxt, wake_r, wake_nxt;
   logic [15:0] div_r, div_nxt, dcnt_r, dcnt_nxt;
   logic        tick_r, tick_nxt;
   logic        wait_r, wait_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic        hold_r, hold_nxt, restart;
   logic [1:0]  ovl_r, ovl_nxt;
   logic        rx_prev_r;
   logic        rx_sync, rx_wake, idle;
   logic        acc, do_wr, is_cfg;
   logic [15:0] wmask, ctrl1_v, cfg2_v, status_v;

   cmc_rx_filter #(.TAPS(FILT_TAPS)) u_filt (
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .rx_pin_in   (can_rx_line_in),
      .filt_en_in  (sleep_in && wakflt_r),
      .rx_sync_out (rx_sync),
      .rx_out      (rx_wake)
   );

   cmc_idle_det #(.IDLE_BITS(IDLE_BITS)) u_idle (
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .bit_tick_in (tick_r),
      .rx_in       (rx_sync),
      .restart_in  (restart),
      .idle_out    (idle)
   );

   // ----------------------------------------------------------------
   // Register views
   // ----------------------------------------------------------------
   always_comb begin
      ctrl1_v = 16'h0000;
      ctrl1_v[`CMC_B_SIDL]  = sidl_r;
      ctrl1_v[`CMC_B_ABORT] = abort_r;
      ctrl1_v[`CMC_F_REQ_HI:`CMC_F_REQ_LO] = req_r;
      ctrl1_v[`CMC_F_STA_HI:`CMC_F_STA_LO] = sta_r;
      ctrl1_v[`CMC_B_CAP]   = cap_en_r;
      ctrl1_v[`CMC_B_WIN]   = win_r;
      cfg2_v = 16'h0000;
      cfg2_v[`CMC_B_WAKFLT] = wakflt_r;
      status_v = {12'h000, sleep_in && wakflt_r, wake_r, hold_r, idle};
      wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   end

   // ----------------------------------------------------------------
   // Bus slave, registers and mode sequencing
   // ----------------------------------------------------------------
   always_comb begin
      sidl_nxt   = sidl_r;
      abort_nxt  = abort_r;
      req_nxt    = req_r;
      sta_nxt    = sta_r;
      cap_en_nxt = cap_en_r;
      win_nxt    = win_r;
      wakflt_nxt = wakflt_r;
      wake_nxt   = wake_r;
      div_nxt    = div_r;
      hold_nxt   = hold_r;
      rd_nxt     = rd_r;
      restart    = 1'b0;
      is_cfg     = (sta_r == CMC_CONFIG);
      // A request is answered one cycle after it is first seen.
      wait_nxt   = 1'b1;
      do_wr      = 1'b0;
      if ((avs_read_in || avs_write_in) && wait_r) begin
         wait_nxt = 1'b0;
         rd_nxt   = 32'h0000_0000;
         if (avs_address_in == `CMC_OFS_CTRL1)
            rd_nxt = {16'h0000, ctrl1_v};
         else if (avs_address_in == `CMC_OFS_CFG2)
            rd_nxt = {16'h0000, cfg2_v};
         else if (avs_address_in == `CMC_OFS_BITDIV)
            rd_nxt = {16'h0000, div_r};
         else if (avs_address_in == `CMC_OFS_STATUS)
            rd_nxt = {16'h0000, status_v};
      end
      do_wr = avs_write_in && !wait_r;
      // Abort-all clears itself; a new write in the same cycle wins.
      if (abort_done_in)
         abort_nxt = 1'b0;
      if (do_wr && avs_address_in == `CMC_OFS_CTRL1) begin
         // The mode request must stay writable or config is a trap.
         req_nxt = (req_r & ~wmask[10:8]) |
                   (avs_writedata_in[10:8] & wmask[10:8]);
         if (wmask[0])
            win_nxt = avs_writedata_in[`CMC_B_WIN];
         if (wmask[0])
            cap_en_nxt = avs_writedata_in[`CMC_B_CAP];
         if (wmask[8] && is_cfg)
            sidl_nxt = avs_writedata_in[`CMC_B_SIDL];
         if (wmask[8] && avs_writedata_in[`CMC_B_ABORT])
            abort_nxt = 1'b1;
      end else if (do_wr && avs_address_in == `CMC_OFS_CFG2) begin
         if (wmask[8] && is_cfg)
            wakflt_nxt = avs_writedata_in[`CMC_B_WAKFLT];
      end else if (do_wr && avs_address_in == `CMC_OFS_BITDIV) begin
         if (is_cfg)
            div_nxt = (div_r & ~wmask) |
                      (avs_writedata_in[15:0] & wmask);
      end else if (do_wr && avs_address_in == `CMC_OFS_STATUS) begin
         if (wmask[0] && avs_writedata_in[2])
            wake_nxt = 1'b0;
      end
      // Bus activity in disable mode wakes; set wins over clear.
      if (sta_r == CMC_DISABLE && rx_prev_r && !rx_wake)
         wake_nxt = 1'b1;
      // Leaving an off-line mode needs no idle bus.
      acc = (sta_r == CMC_CONFIG || sta_r == CMC_DISABLE) ? 1'b1 : idle;
      if (req_r == CMC_CONFIG && tx_busy_in)
         acc = 1'b0;
      if (req_r != sta_r && req_r != CMC_RSV5 && req_r != CMC_RSV6 &&
          acc) begin
         sta_nxt = cmc_mode_e'(req_r);
         if (req_r == CMC_NORMAL || req_r == CMC_LOOP) begin
            restart  = 1'b1;
            hold_nxt = 1'b1;
         end
      end
      if (hold_r && idle)
         hold_nxt = 1'b0;
      if (hold_r && req_r == CMC_DISABLE)
         hold_nxt = 1'b0;
   end

   // ----------------------------------------------------------------
   // Bit-rate divider and overload limit
   // ----------------------------------------------------------------
   always_comb begin
      tick_nxt = 1'b0;
      dcnt_nxt = dcnt_r + 16'h0001;
      if (dcnt_r >= div_r - 16'h0001) begin
         dcnt_nxt = 16'h0000;
         tick_nxt = 1'b1;
      end
      ovl_nxt = ovl_r;
      if (frame_start_in)
         ovl_nxt = 2'h0;
      else if (ovl_req_in && ovl_r < 2'(`CMC_OVL_MAX))
         ovl_nxt = ovl_r + 2'h1;
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sidl_r    <= 1'b0;
         abort_r   <= 1'b0;
         req_r     <= CMC_CONFIG;
         sta_r     <= CMC_CONFIG;
         cap_en_r  <= 1'b0;
         win_r     <= 1'b0;
         wakflt_r  <= 1'b0;
         wake_r    <= 1'b0;
         div_r     <= `CMC_BITDIV_RST;
         dcnt_r    <= 16'h0000;
         tick_r    <= 1'b0;
         wait_r    <= 1'b1;
         rd_r      <= 32'h0000_0000;
         hold_r    <= 1'b0;
         ovl_r     <= 2'h0;
         rx_prev_r <= 1'b1;
      end else begin
         sidl_r    <= sidl_nxt;
         abort_r   <= abort_nxt;
         req_r     <= req_nxt;
         sta_r     <= sta_nxt;
         cap_en_r  <= cap_en_nxt;
         win_r     <= win_nxt;
         wakflt_r  <= wakflt_nxt;
         wake_r    <= wake_nxt;
         div_r     <= div_nxt;
         dcnt_r    <= dcnt_nxt;
         tick_r    <= tick_nxt;
         wait_r    <= wait_nxt;
         rd_r      <= rd_nxt;
         hold_r    <= hold_nxt;
         ovl_r     <= ovl_nxt;
         rx_prev_r <= rx_wake;
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs: mode-dependent ones plus capture, halt and overload grant
   // ----------------------------------------------------------------
   logic tx_mode, on_line;
   logic o_txl, o_txoe, o_rxown, o_erx, o_eng, o_tx, o_rx, o_ack;
   logic o_clr, o_hold, o_part, o_can, o_cap, o_halt, o_ovl, o_rep;
   logic r_txl, r_txoe, r_rxown, r_erx, r_eng, r_tx, r_rx, r_ack;
   logic r_clr, r_hold, r_part, r_can, r_cap, r_halt, r_ovl, r_rep;

   always_comb begin
      tx_mode = (sta_r == CMC_NORMAL || sta_r == CMC_LOOP);
      on_line = tx_mode || sta_r == CMC_LISTEN || sta_r == CMC_LSNALL;
      o_eng   = on_line;
      o_tx    = tx_mode && !hold_r;
      o_rx    = on_line;
      o_ack   = sta_r == CMC_NORMAL || sta_r == CMC_LOOP;
      o_clr   = sta_r == CMC_CONFIG;
      o_hold  = sta_r == CMC_DISABLE || sta_r == CMC_LISTEN ||
                sta_r == CMC_LSNALL;
      o_part  = sta_r == CMC_LSNALL;
      o_txoe  = sta_r == CMC_NORMAL || sta_r == CMC_LSNALL;
      o_txl   = o_txoe ? eng_tx_in : 1'b1;
      o_rxown = o_txoe || sta_r == CMC_LISTEN;
      o_erx   = (sta_r == CMC_LOOP) ? eng_tx_in : rx_sync;
      o_can   = hold_r && tx_pending_in && req_r == CMC_DISABLE;
      o_cap   = rx_done_in && cap_en_r;
      o_halt  = sidl_r && cpu_idle_in;
      o_ovl   = ovl_req_in && !frame_start_in &&
                ovl_r < 2'(`CMC_OVL_MAX);
      o_rep   = rtr_match_in && tx_mode;
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         {r_txl, r_txoe, r_rxown, r_erx} <= 4'h9;
         {r_eng, r_tx, r_rx, r_ack}      <= 4'h0;
         {r_clr, r_hold, r_part, r_can}  <= 4'h8;
         {r_cap, r_halt, r_ovl, r_rep}   <= 4'h0;
      end else begin
         {r_txl, r_txoe, r_rxown, r_erx} <= {o_txl, o_txoe, o_rxown, o_erx};
         {r_eng, r_tx, r_rx, r_ack}      <= {o_eng, o_tx, o_rx, o_ack};
         {r_clr, r_hold, r_part, r_can}  <= {o_clr, o_hold, o_part, o_can};
         {r_cap, r_halt, r_ovl, r_rep}   <= {o_cap, o_halt, o_ovl, o_rep};
      end
   end

   assign avs_readdata_out    = rd_r;
   assign avs_waitrequest_out = wait_r;
   assign bit_tick_out        = tick_r;
   assign mode_status_out     = sta_r;
   assign abort_all_out       = abort_r;
   assign window_sel_out      = win_r;
   assign can_tx_line_out     = r_txl;
   assign can_tx_oe_out       = r_txoe;
   assign can_rx_own_out      = r_rxown;
   assign eng_rx_out          = r_erx;
   assign engine_en_out       = r_eng;
   assign tx_en_out           = r_tx;
   assign rx_en_out           = r_rx;
   assign ack_err_en_out      = r_ack;
   assign err_clear_out       = r_clr;
   assign err_hold_out        = r_hold;
   assign keep_partial_out    = r_part;
   assign tx_cancel_out       = r_can;
   assign capture_out         = r_cap;
   assign halt_out            = r_halt;
   assign ovl_grant_out       = r_ovl;
   assign auto_reply_out      = r_rep;
endmodule

// >>> logic/cmc_pkg.sv
// Types shared by the mode block and its helpers.
package cmc_pkg;
   typedef enum logic [2:0] {
      CMC_NORMAL  = 3'h0,
      CMC_DISABLE = 3'h1,
      CMC_LOOP    = 3'h2,
      CMC_LISTEN  = 3'h3,
      CMC_CONFIG  = 3'h4,
      CMC_RSV5    = 3'h5,
      CMC_RSV6    = 3'h6,
      CMC_LSNALL  = 3'h7
   } cmc_mode_e;
endpackage

// >>> logic/cmc_rx_filter.sv
// Receive pin synchroniser with switchable low-pass filter.
`timescale 1ns/100ps
`include "cmc_cfg.svh"
module cmc_rx_filter #(
   parameter int TAPS = `CMC_FILT_TAPS
) (
   input  wire logic clock_in,     // module clock
   input  wire logic rst_n_in,     // async reset, active low
   input  wire logic rx_pin_in,    // raw receive pin
   input  wire logic filt_en_in,   // filter active
   output logic      rx_sync_out,  // synchronised level
   output logic      rx_out        // filtered or plain level
);
   import cmc_pkg::*;
   logic            meta_r, sync_r, filt_r, filt_nxt;
   logic [TAPS-1:0] taps_r, taps_nxt;

   always_comb begin
      taps_nxt = {taps_r[TAPS-2:0], sync_r};
      filt_nxt = filt_r;
      // While filt_en_in is set, glitches shorter than the tap window never reach the wake logic.
      if (&taps_r)
         filt_nxt = 1'b1;
      else if (~|taps_r)
         filt_nxt = 1'b0;
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         taps_r <= '1;
         filt_r <= 1'b1;
      end else begin
         meta_r <= rx_pin_in;
         sync_r <= meta_r;
         taps_r <= taps_nxt;
         filt_r <= filt_nxt;
      end
   end

   assign rx_sync_out = sync_r;
   assign rx_out      = filt_en_in ? filt_r : sync_r;
endmodule

// >>> verif/cmc_can_node.sv
// Behavioural CAN bus node that can put a burst of bits on the bus.
`timescale 1ns/100ps
module cmc_can_node #(
   parameter int LEN = 48
) (
   input  wire logic clock_in,  // clock
   input  wire logic send_in,   // start a frame
   input  wire logic dut_tx_in, // controller pin level
   input  wire logic dut_oe_in, // controller drives pin
   output logic      bus_out    // wired-and bus level
);
   int         left = 0;
   logic [3:0] lfsr = 4'h9;
   always @(posedge clock_in) begin
      left <= (send_in && left == 0) ? LEN : (left > 0 ? left - 1 : 0);
      lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
   end
   // The bias pulls an undriven bus recessive, so idle always reads 1.
   assign bus_out = (left == 0 || lfsr[0]) && (!dut_oe_in || dut_tx_in);
endmodule

// >>> verif/cmc_checker.sv
// Concurrent checks on the ports of the CAN mode controller.
`timescale 1ns/100ps
module cmc_checker
   import cmc_pkg::*;
#(
   parameter int IDLE_BITS = 11
) (
   input wire logic clock_in,               // clock
   input wire logic rst_n_in,               // reset
   input wire logic avs_read_in,            // read
   input wire logic avs_write_in,           // write
   input wire logic avs_waitrequest_out,    // stall
   input wire logic can_rx_line_in,         // bus pin
   input wire logic tx_busy_in,             // frame out
   input wire logic rx_done_in,             // received
   input wire logic frame_start_in,         // frame start
   input wire logic eng_tx_in,              // engine tx
   input wire cmc_pkg::cmc_mode_e mode_status_out, // mode
   input wire logic tx_en_out,              // tx allowed
   input wire logic err_clear_out,          // counters cleared
   input wire logic err_hold_out,           // counters frozen
   input wire logic can_tx_oe_out,          // pin driven
   input wire logic can_rx_own_out,         // pin owned
   input wire logic ack_err_en_out,         // ack allowed
   input wire logic eng_rx_out,             // engine rx
   input wire logic capture_out,            // timestamp
   input wire logic ovl_grant_out           // overload
);
   // ------------------------------------------------------------
   // Helper counters
   // ------------------------------------------------------------
   // Raw pin cycles are an upper bound on recessive bit times.
   logic [7:0] hi_r, hi_nxt;
   logic [1:0] ovl_r, ovl_nxt;
   always_comb begin
      hi_nxt = can_rx_line_in ? hi_r + {7'h00, hi_r != 8'hFF} : 8'h00;
      ovl_nxt = frame_start_in ? 2'h0 :
                ovl_r + {1'b0, ovl_grant_out && ovl_r != 2'h3};
   end
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hi_r <= 8'h00;
         ovl_r <= 2'h0;
      end else begin
         hi_r <= hi_nxt;
         ovl_r <= ovl_nxt;
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking dcb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);
   a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("answer held too long");
   a_req_answered: assert property ((avs_read_in || avs_write_in) &&
      avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("request not answered");
   a_status_legal: assert property (!(mode_status_out inside {CMC_RSV5, CMC_RSV6}))
      else $error("reserved mode reported");
   a_leave_on_idle: assert property ($changed(mode_status_out) &&
      $past(mode_status_out) == CMC_NORMAL |-> $past(hi_r) >= IDLE_BITS)
      else $error("left normal on busy bus");
   a_config_after_tx: assert property ($changed(mode_status_out) &&
      mode_status_out == CMC_CONFIG && $past(mode_status_out) != CMC_DISABLE
      |-> !$past(tx_busy_in))
      else $error("config entered mid-frame");
   a_config_quiet: assert property (mode_status_out == CMC_CONFIG &&
      $stable(mode_status_out) |-> !tx_en_out && err_clear_out)
      else $error("config mode not quiet");
   a_disable_quiet: assert property (mode_status_out == CMC_DISABLE &&
      $stable(mode_status_out) |-> !tx_en_out && !can_tx_oe_out && err_hold_out)
      else $error("disable mode not quiet");
   a_listen_passive: assert property (mode_status_out == CMC_LISTEN &&
      $stable(mode_status_out) |-> !can_tx_oe_out && !ack_err_en_out)
      else $error("listen mode drives the bus");
   a_normal_pins: assert property (mode_status_out == CMC_NORMAL &&
      $stable(mode_status_out) |-> can_tx_oe_out && can_rx_own_out)
      else $error("normal mode without bus pins");
   a_loop_route: assert property (mode_status_out == CMC_LOOP &&
      $past(mode_status_out, 2) == CMC_LOOP |-> eng_rx_out == $past(eng_tx_in))
      else $error("loopback path broken");
   a_capture_cause: assert property (capture_out |-> $past(rx_done_in))
      else $error("capture pulse without reception");
   a_overload_max: assert property (ovl_r <= 2'h2)
      else $error("too many overload grants");
   cover property (mode_status_out == CMC_LOOP);
   cover property (capture_out);
   cover property (ovl_grant_out);
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the CAN operating-mode controller.
`timescale 1ns/100ps
module tb_top;
   import cmc_pkg::*;
   logic        clock_in = 1'b0, rst_n_in = 1'b0;
   logic [3:0]  avs_address_in = 4'h0, avs_byteenable_in = 4'h3;
   logic        avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0000_0000, avs_readdata_out;
   logic        avs_waitrequest_out, can_rx_line_in, can_tx_line_out;
   logic        can_tx_oe_out, can_rx_own_out, eng_rx_out, bit_tick_out;
   logic        eng_tx_in = 1'b1, tx_busy_in = 1'b0, tx_pending_in = 1'b0;
   logic        abort_done_in = 1'b0, rx_done_in = 1'b0, rtr_match_in = 1'b0;
   logic        ovl_req_in = 1'b0, frame_start_in = 1'b0, sleep_in = 1'b0;
   logic        cpu_idle_in = 1'b0, send = 1'b0, r;
   logic        engine_en_out, tx_en_out, rx_en_out, ack_err_en_out;
   logic        err_clear_out, err_hold_out, keep_partial_out, halt_out;
   logic        abort_all_out, tx_cancel_out, capture_out, window_sel_out;
   logic        ovl_grant_out, auto_reply_out;
   cmc_mode_e   mode_status_out;
   logic [15:0] ctl = 16'h0480, q;
   logic [2:0]  codes [6] = '{3'h0, 3'h2, 3'h3, 3'h7, 3'h1, 3'h4};
   int          err_total = 0, check_count = 0, n;
   cmc_mode_ctrl DUT (.*);
   cmc_can_node NODE (.clock_in(clock_in), .send_in(send),
      .dut_tx_in(can_tx_line_out), .dut_oe_in(can_tx_oe_out),
      .bus_out(can_rx_line_in));
   always #4 clock_in = ~clock_in;
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk_val({15'h0000, g}, {15'h0000, e});
   endtask
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [15:0] d);
      @(posedge clock_in);
      avs_address_in <= a;
      avs_writedata_in <= {16'h0000, d};
      avs_write_in <= w;
      avs_read_in <= !w;
      do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
      q = avs_readdata_out[15:0];
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask
   task automatic req(input logic [2:0] m);
      ctl[10:8] = m;
      bus(1'b1, 4'h0, ctl);
   endtask
   task automatic wait_mode(input cmc_mode_e m);
      n = 0;
      while (mode_status_out !== m && n < 400) begin
         @(posedge clock_in);
         n++;
      end
      chk_val({13'h0000, mode_status_out}, {13'h0000, m});
   endtask
   task automatic print_verdict();
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (6000) @(posedge clock_in);
      err_total++;
      print_verdict();
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      void'($urandom(47));
      repeat (3) @(posedge clock_in);
      rst_n_in <= 1'b1;
      bus(1'b0, 4'h0, 16'h0000);
      chk_val(q, 16'h0480);
      bus(1'b0, 4'h2, 16'h0000);
      chk_val(q, 16'h0000);
      bus(1'b1, 4'h8, 16'h0004);
      bus(1'b1, 4'h4, 16'h4000);
      bus(1'b0, 4'h4, 16'h0000);
      chk_val(q, 16'h4000);
      ctl[13] = 1'b1;
      bus(1'b1, 4'h0, ctl);
      cpu_idle_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      chk_bit(halt_out, 1'b1);
      cpu_idle_in <= 1'b0;
      ctl[13] = 1'b0;
      bus(1'b1, 4'h0, ctl);
      req(3'h5);
      repeat (20) @(posedge clock_in);
      chk_val({13'h0000, mode_status_out}, 16'h0004);
      foreach (codes[i]) begin
         req(codes[i]);
         wait_mode(cmc_mode_e'(codes[i]));
         repeat (3) @(posedge clock_in);
         bus(1'b0, 4'h0, 16'h0000);
         chk_val({13'h0000, q[7:5]}, {13'h0000, codes[i]});
         case (codes[i])
            3'h0: chk_bit(can_tx_oe_out && engine_en_out, 1'b1);
            3'h1: chk_bit(can_rx_own_out, 1'b0);
            3'h3: chk_bit(ack_err_en_out, 1'b0);
            3'h7: chk_bit(keep_partial_out, 1'b1);
            3'h4: chk_bit(err_clear_out, 1'b1);
            default: begin
               for (int k = 0; k < 8; k++) begin
                  r = 1'($urandom());
                  eng_tx_in <= r;
                  repeat (2) @(posedge clock_in);
                  chk_bit(eng_rx_out, r);
               end
               eng_tx_in <= 1'b1;
            end
         endcase
      end
      req(3'h0);
      tx_pending_in <= 1'b1;
      req(3'h1);
      n = 0;
      while (tx_cancel_out !== 1'b1 && n < 60) begin
         @(posedge clock_in);
         n++;
      end
      chk_bit(tx_cancel_out, 1'b1);
      tx_pending_in <= 1'b0;
      wait_mode(CMC_DISABLE);
      req(3'h0);
      wait_mode(CMC_NORMAL);
      tx_busy_in <= 1'b1;
      send <= 1'b1;
      req(3'h4);
      send <= 1'b0;
      bus(1'b1, 4'h8, 16'h0009);
      repeat (40) @(posedge clock_in);
      chk_val({13'h0000, mode_status_out}, 16'h0000);
      repeat (150) @(posedge clock_in);
      chk_val({13'h0000, mode_status_out}, 16'h0000);
      tx_busy_in <= 1'b0;
      wait_mode(CMC_CONFIG);
      bus(1'b0, 4'h8, 16'h0000);
      chk_val(q, 16'h0004);
      req(3'h0);
      wait_mode(CMC_NORMAL);
      r = 1'($urandom());
      ctl[3] = 1'b1;
      ctl[0] = r;
      ctl[12] = 1'b1;
      bus(1'b1, 4'h0, ctl);
      rx_done_in <= 1'b1;
      @(posedge clock_in);
      rx_done_in <= 1'b0;
      @(posedge clock_in);
      chk_bit(capture_out, 1'b1);
      chk_bit(window_sel_out, r);
      chk_bit(abort_all_out, 1'b1);
      abort_done_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      chk_bit(abort_all_out, 1'b0);
      abort_done_in <= 1'b0;
      frame_start_in <= 1'b1;
      @(posedge clock_in);
      frame_start_in <= 1'b0;
      n = 0;
      for (int k = 0; k < 8; k++) begin
         ovl_req_in <= !k[0];
         @(posedge clock_in);
         n += int'(ovl_grant_out);
      end
      chk_val(16'(n), 16'h0002);
      rtr_match_in <= 1'b1;
      @(posedge clock_in);
      rtr_match_in <= 1'b0;
      @(posedge clock_in);
      chk_bit(auto_reply_out, 1'b1);
      print_verdict();
   end
endmodule
bind cmc_mode_ctrl cmc_checker #(.IDLE_BITS(IDLE_BITS)) CHK (.*);
